//--- hw/cce_exec.sv
// Execution of call, clear-register and watchdog-clear instructions
`timescale 1ns/1ns
`include "cce_defs.svh"

module cce_exec (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Instruction stream
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_word_i,
    // Core registers
    input wire logic [7:0] working_i,
    input wire logic [7:0] status_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [11:0] index_base_i,
    // Watchdog events
    input wire logic timeout_evt_i,
    input wire logic sleep_evt_i,
    // Avalon-MM slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Program counter and stack
    output logic [20:0] pc_o,
    output logic stack_push_o,
    output logic [20:0] stack_top_o,
    // Shadow registers
    output logic shadow_we_o,
    output logic [7:0] working_shadow_o,
    output logic [7:0] status_shadow_o,
    output logic [3:0] bank_select_shadow_o,
    // Data memory write and zero flag
    output logic fw_we_o,
    output logic [11:0] fw_addr_o,
    output logic [7:0] fw_data_o,
    output logic zero_set_o,
    // Watchdog and call busy
    output logic watchdog_counter_clr_o,
    output logic postscaler_clr_o,
    output logic timeout_flag_n_o,
    output logic powerdown_flag_n_o,
    output logic busy_o
);

    // ****************************************
    // Phases and decode
    // ****************************************
    cce_q_if qif ();

    cce_qgen u_qgen (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .qi(qif.src)
    );

    wire q1 = qif.q[`CCE_Q1];
    wire q2 = qif.q[`CCE_Q2];
    wire q3 = qif.q[`CCE_Q3];
    wire q4 = qif.q[`CCE_Q4];

    cce_pkg::cce_state_e st_q;
    logic [15:0] ir_q;
    logic ir_ok_q;
    logic [7:0] klow_q;
    logic [20:0] pc_q;
    logic ext_en_q;

    wire [6:0] op = ir_q[`CCE_OP_MSB:`CCE_OP_LSB];
    wire sa = ir_q[`CCE_BIT_SA];
    wire [7:0] f = ir_q[7:0];
    wire execing = ir_ok_q && st_q == cce_pkg::CCE_EXEC;
    wire is_call = execing && op == `CCE_OP_CALL;
    wire is_clr_reg = execing && op == `CCE_OP_CLR_REG;
    wire is_wdog_clr = execing && ir_q == `CCE_OP_WDOG_CLR;
    wire call_w2 = instr_word_i[15:12] == `CCE_CALL2_HI;

    // ****************************************
    // Clear-register address resolution
    // ****************************************
    wire indexed = ext_en_q && !sa && f <= `CCE_IDX_MAX;
    wire [11:0] addr_idx = index_base_i + {4'h0, f};
    wire [11:0] addr_acc = (f < `CCE_ACC_SPLIT) ?
        {`CCE_ACC_LO_BANK, f} : {`CCE_ACC_HI_BANK, f};
    wire [11:0] addr_bank = {bank_select_reg_i, f};
    wire [11:0] addr_sel = indexed ? addr_idx :
        (sa ? addr_bank : addr_acc);

    wire [20:0] pc_ret = pc_q + `CCE_RET_OFS;
    wire [20:0] pc_next = pc_q + `CCE_PC_STEP;
    wire [20:0] pc_call = {instr_word_i[11:0], klow_q, 1'b0};

    // ****************************************
    // Instruction sequencing
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ir_q <= 16'h0000;
            ir_ok_q <= 1'b0;
        end else if (q1 && st_q == cce_pkg::CCE_EXEC) begin
            ir_q <= instr_word_i;
            ir_ok_q <= instr_valid_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_q <= cce_pkg::CCE_EXEC;
            pc_q <= `CCE_PC_RST;
            klow_q <= 8'h00;
        end else begin
            if (q2 && is_call) begin
                klow_q <= f;
            end
            if (q4) begin
                if (is_call) begin
                    pc_q <= pc_call;
                    st_q <= cce_pkg::CCE_CALL2;
                end else if (st_q == cce_pkg::CCE_CALL2) begin
                    st_q <= cce_pkg::CCE_EXEC;
                end else if (ir_ok_q) begin
                    pc_q <= pc_next;
                end
            end
        end
    end

    // ****************************************
    // Stack push and shadows (third quarter)
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            stack_push_o <= 1'b0;
            stack_top_o <= `CCE_PC_RST;
            shadow_we_o <= 1'b0;
            working_shadow_o <= 8'h00;
            status_shadow_o <= 8'h00;
            bank_select_shadow_o <= 4'h0;
        end else begin
            stack_push_o <= q3 && is_call;
            shadow_we_o <= q3 && is_call && sa;
            if (q3 && is_call) begin
                stack_top_o <= pc_ret;
            end
            if (q3 && is_call && sa) begin
                working_shadow_o <= working_i;
                status_shadow_o <= status_i;
                bank_select_shadow_o <= bank_select_reg_i;
            end
        end
    end

    // ****************************************
    // Clear register and watchdog clear
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            fw_we_o <= 1'b0;
            fw_addr_o <= 12'h000;
            zero_set_o <= 1'b0;
            watchdog_counter_clr_o <= 1'b0;
            postscaler_clr_o <= 1'b0;
        end else begin
            fw_we_o <= q4 && is_clr_reg;
            zero_set_o <= q4 && is_clr_reg;
            if (q4 && is_clr_reg) begin
                fw_addr_o <= addr_sel;
            end
            watchdog_counter_clr_o <= q4 && is_wdog_clr;
            postscaler_clr_o <= q4 && is_wdog_clr;
        end
    end

    assign fw_data_o = 8'h00;

    // Watchdog clear wins over a same-cycle timeout or sleep event
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            timeout_flag_n_o <= `CCE_FLAG_RST;
            powerdown_flag_n_o <= `CCE_FLAG_RST;
        end else if (q4 && is_wdog_clr) begin
            timeout_flag_n_o <= 1'b1;
            powerdown_flag_n_o <= 1'b1;
        end else begin
            if (timeout_evt_i) begin
                timeout_flag_n_o <= 1'b0;
            end
            if (sleep_evt_i) begin
                powerdown_flag_n_o <= 1'b0;
            end
        end
    end

    assign pc_o = pc_q;
    assign busy_o = st_q == cce_pkg::CCE_CALL2;

    // ****************************************
    // Avalon-MM register slave
    // ****************************************
    logic ack_q;
    wire req = avs_read_i || avs_write_i;
    wire sel_ctrl = avs_address_i == `CCE_REG_CTRL;
    wire sel_stat = avs_address_i == `CCE_REG_STAT;
    wire sel_pc = avs_address_i == `CCE_REG_PC;
    wire ctrl_wr = avs_write_i && ack_q && sel_ctrl && avs_byteenable_i[0];
    wire [31:0] stat_word = {29'h0, busy_o, powerdown_flag_n_o,
        timeout_flag_n_o};
    wire [31:0] rd_mux = sel_ctrl ? {31'h0, ext_en_q} :
        sel_stat ? stat_word :
        sel_pc ? {11'h0, pc_q} : 32'h0;

    assign avs_waitrequest_o = req && !ack_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ack_q <= 1'b0;
            avs_readdata_o <= 32'h0;
            ext_en_q <= `CCE_CTRL_RST;
        end else begin
            ack_q <= req && !ack_q;
            if (avs_read_i && !ack_q) begin
                avs_readdata_o <= rd_mux;
            end
            if (ctrl_wr) begin
                ext_en_q <= avs_writedata_i[`CCE_CTRL_EXT];
            end
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    sequence s_call_q3;
        q3 && is_call;
    endsequence
    sequence s_call_end;
        ##1 stack_push_o ##1 (pc_o == $past(pc_call)) ##1 busy_o;
    endsequence

    property p_push_ret;
        s_call_q3 |=> stack_push_o && stack_top_o == $past(pc_ret);
    endproperty
    a_push_ret: assert property (p_push_ret)
        else $error("call pushed wrong return address");

    property p_shadow;
        s_call_q3 |=> (shadow_we_o == $past(sa)) &&
            ($past(sa) || $stable(working_shadow_o));
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("shadow update does not follow select bit");

    property p_call_seq;
        s_call_q3 |-> s_call_end;
    endproperty
    a_call_seq: assert property (p_call_seq)
        else $error("call quarter sequence broken");

    property p_call_pc;
        q4 && is_call |=> pc_o[0] == 1'b0 && pc_o[8:1] == $past(klow_q);
    endproperty
    a_call_pc: assert property (p_call_pc)
        else $error("call target not loaded");

    property p_two_cycles;
        q4 && is_call |=> busy_o [*4] ##1 !busy_o;
    endproperty
    a_two_cycles: assert property (p_two_cycles)
        else $error("call not two cycles long");

    property p_clr_reg;
        q4 && is_clr_reg |=> fw_we_o && zero_set_o && fw_data_o == 8'h00;
    endproperty
    a_clr_reg: assert property (p_clr_reg)
        else $error("clear register did not write zero");

    property p_bank;
        q4 && is_clr_reg && sa |=>
            fw_addr_o == {$past(bank_select_reg_i), $past(f)};
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank select address wrong");

    property p_access;
        q4 && is_clr_reg && !sa && !indexed |=> fw_addr_o[7:0] == $past(f)
            && fw_addr_o[11:8] == ($past(f) < `CCE_ACC_SPLIT ?
            `CCE_ACC_LO_BANK : `CCE_ACC_HI_BANK);
    endproperty
    a_access: assert property (p_access)
        else $error("access bank address wrong");

    property p_indexed;
        q4 && is_clr_reg && ext_en_q && !sa && f <= `CCE_IDX_MAX |=>
            fw_addr_o == $past(index_base_i) + {4'h0, $past(f)};
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed offset address wrong");

    property p_wdog_clr;
        q4 && is_wdog_clr |=> watchdog_counter_clr_o && postscaler_clr_o
            ##1 !watchdog_counter_clr_o;
    endproperty
    a_wdog_clr: assert property (p_wdog_clr)
        else $error("watchdog clear pulse wrong");

    property p_flags;
        q4 && is_wdog_clr |=> timeout_flag_n_o && powerdown_flag_n_o;
    endproperty
    a_flags: assert property (p_flags)
        else $error("watchdog clear did not set flags");

endmodule

//--- hw/cce_defs.svh
// Constants for the clear and call execution block
`ifndef CCE_DEFS_SVH
`define CCE_DEFS_SVH

// ****************************************
// Opcode fields
// ****************************************
`define CCE_OP_CALL 7'h76
`define CCE_OP_CLR_REG 7'h35
`define CCE_OP_WDOG_CLR 16'h0004
`define CCE_CALL2_HI 4'hf
`define CCE_OP_MSB 15
`define CCE_OP_LSB 9
`define CCE_BIT_SA 8

// ****************************************
// Addressing
// ****************************************
`define CCE_IDX_MAX 8'h5f
`define CCE_ACC_SPLIT 8'h60
`define CCE_ACC_HI_BANK 4'hf
`define CCE_ACC_LO_BANK 4'h0

// ****************************************
// Program counter
// ****************************************
`define CCE_PC_STEP 21'h000002
`define CCE_RET_OFS 21'h000004
`define CCE_PC_RST 21'h000000

// ****************************************
// Quarter phases (one-hot bit index)
// ****************************************
`define CCE_Q1 0
`define CCE_Q2 1
`define CCE_Q3 2
`define CCE_Q4 3
`define CCE_Q_RST 4'h1

// ****************************************
// Register map (byte addresses)
// ****************************************
`define CCE_REG_CTRL 4'h0
`define CCE_REG_STAT 4'h4
`define CCE_REG_PC 4'h8
`define CCE_CTRL_EXT 0
`define CCE_STAT_TMO 0
`define CCE_STAT_PWR 1
`define CCE_STAT_BUSY 2
`define CCE_CTRL_RST 1'b0
`define CCE_FLAG_RST 1'b1

`endif

//--- hw/cce_pkg.sv
// Types for the clear and call execution block
package cce_pkg;

    typedef enum logic [0:0] {
        CCE_EXEC = 1'b0,
        CCE_CALL2 = 1'b1
    } cce_state_e;

endpackage

//--- hw/cce_q_if.sv
// Quarter-cycle phase carrier between sequencer and executor
`timescale 1ns/1ns

interface cce_q_if;
    logic [3:0] q;

    modport src (output q);
    modport dst (input q);
endinterface

//--- hw/cce_qgen.sv
// Quarter-cycle sequencer: one-hot Q1..Q4, one clock each
`timescale 1ns/1ns
`include "cce_defs.svh"

module cce_qgen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Phase output
    cce_q_if.src qi
);

    logic [3:0] q_q;
    logic [3:0] q_d;

    assign q_d = {q_q[2:0], q_q[3]};
    assign qi.q = q_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_q <= `CCE_Q_RST;
        end else begin
            q_q <= q_d;
        end
    end

endmodule

//--- verif/testbench.sv
// Self-checking bench for the clear and call execution block
`timescale 1ns/1ns

module testbench;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_word_i = 16'h0000;
    logic [7:0] working_i = 8'h00;
    logic [7:0] status_i = 8'h00;
    logic [3:0] bank_select_reg_i = 4'h0;
    logic [11:0] index_base_i = 12'h000;
    logic timeout_evt_i = 1'b0;
    logic sleep_evt_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o, stack_push_o, shadow_we_o, fw_we_o, zero_set_o;
    logic [20:0] pc_o, stack_top_o;
    logic [7:0] working_shadow_o, status_shadow_o, fw_data_o;
    logic [3:0] bank_select_shadow_o;
    logic [11:0] fw_addr_o;
    logic watchdog_counter_clr_o, postscaler_clr_o, busy_o;
    logic timeout_flag_n_o, powerdown_flag_n_o;
    logic [1:0] qc;
    int n_mismatch = 0;
    int compares = 0;
    // Reference model state
    logic [20:0] m_pc = 21'h0;
    logic m_ext = 1'b0, m_tmo = 1'b1, m_pwr = 1'b1, m_sv = 1'b0;
    logic [19:0] m_sh;

    cce_exec DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .instr_valid_i(instr_valid_i),
        .instr_word_i(instr_word_i), .working_i(working_i),
        .status_i(status_i), .bank_select_reg_i(bank_select_reg_i),
        .index_base_i(index_base_i), .timeout_evt_i(timeout_evt_i),
        .sleep_evt_i(sleep_evt_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .pc_o(pc_o),
        .stack_push_o(stack_push_o), .stack_top_o(stack_top_o),
        .shadow_we_o(shadow_we_o), .working_shadow_o(working_shadow_o),
        .status_shadow_o(status_shadow_o),
        .bank_select_shadow_o(bank_select_shadow_o), .fw_we_o(fw_we_o),
        .fw_addr_o(fw_addr_o), .fw_data_o(fw_data_o),
        .zero_set_o(zero_set_o),
        .watchdog_counter_clr_o(watchdog_counter_clr_o),
        .postscaler_clr_o(postscaler_clr_o),
        .timeout_flag_n_o(timeout_flag_n_o),
        .powerdown_flag_n_o(powerdown_flag_n_o), .busy_o(busy_o)
    );

    // ****************************************
    // Clock and quarter-phase tracking
    // ****************************************
    always #20 clk_i = ~clk_i;

    always_ff @(posedge clk_i) begin
        qc <= resetn_i ? qc + 2'd1 : 2'd0;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic conclude();
        $display("Compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Waits on a condition sampled at each edge, bounded
    task automatic wait_edge(input bit bus);
        int t;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
            if (t > 20) begin
                n_mismatch++;
                conclude();
            end
        end while (bus ? avs_waitrequest_o !== 1'b0 : qc !== 2'd3);
    endtask

    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [31:0] rd);
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_address_i <= a;
        avs_byteenable_i <= be;
        avs_writedata_i <= wd;
        wait_edge(1'b1);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        clk(1);
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] rd;
        av(1'b0, a, 4'hf, 32'h0, rd);
        chk("reg", rd, e);
    endtask

    // One instruction slot from its Q1 to the cycle after its Q4, or two slots for a call
    task automatic run(input logic v, input logic [15:0] w1,
                       input logic [15:0] w2);
        logic call, clr, wdc, s;
        logic [7:0] f;
        logic [11:0] ad;
        call = v && w1[15:9] == 7'h76;
        clr = v && w1[15:9] == 7'h35;
        wdc = v && w1 == 16'h0004;
        s = call & w1[8];
        f = w1[7:0];
        wait_edge(1'b0);
        // Operands driven just before the call have settled by now
        if (w1[8]) begin
            ad = {bank_select_reg_i, f};
        end else if (m_ext && f <= 8'h5f) begin
            ad = index_base_i + 12'(f);
        end else begin
            ad = {(f < 8'h60) ? 4'h0 : 4'hf, f};
        end
        instr_valid_i <= v;
        instr_word_i <= w1;
        clk(1);
        instr_valid_i <= 1'b0;
        clk(2);
        instr_word_i <= w2;
        clk(1);
        if (s) m_sh = {working_i, status_i, bank_select_reg_i};
        m_sv = m_sv | s;
        chk("push", stack_push_o, call);
        if (call) chk("top", stack_top_o, m_pc + 21'h4);
        chk("shw", shadow_we_o, s);
        if (m_sv) chk("shd", {working_shadow_o, status_shadow_o,
            bank_select_shadow_o}, m_sh);
        chk("flg", {timeout_flag_n_o, powerdown_flag_n_o}, {m_tmo, m_pwr});
        if (call) begin
            instr_valid_i <= 1'b1;
            instr_word_i <= {7'h35, 1'b0, 8'($urandom)};
            m_pc = {w2[11:0], w1[7:0], 1'b0};
        end else if (v) m_pc = m_pc + 21'h2;
        if (wdc) {m_tmo, m_pwr} = 2'b11;
        clk(1);
        instr_valid_i <= 1'b0;
        chk("pc", pc_o, m_pc);
        chk("busy", busy_o, call);
        chk("clr", {fw_we_o, zero_set_o}, {clr, clr});
        if (clr) chk("adr", {fw_addr_o, fw_data_o}, {ad, 8'h00});
        chk("wdc", watchdog_counter_clr_o, wdc);
        chk("psc", postscaler_clr_o, wdc);
        chk("flg", {timeout_flag_n_o, powerdown_flag_n_o},
            {m_tmo, m_pwr});
        if (call) begin
            clk(3);
            chk("busy", busy_o, 1'b1);
            clk(1);
            chk("skip", {busy_o, fw_we_o, pc_o}, {2'b00, m_pc});
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [31:0] rd;
        logic [31:0] r;
        int k;
        void'($urandom(32'h6ed2));
        clk(3);
        resetn_i <= 1'b1;
        clk(1);
        av(1'b1, 4'h4, 4'hf, 32'h0, rd);
        rdchk(4'h4, 32'h3);
        rdchk(4'hc, 32'h0);
        av(1'b1, 4'h0, 4'h0, 32'h1, rd);
        rdchk(4'h0, 32'h0);
        for (int i = 0; i < 36; i++) begin
            r = $urandom;
            if (i % 12 == 0) begin
                m_ext = (i / 12) % 2;
                av(1'b1, 4'h0, 4'h1, {31'h0, m_ext}, rd);
                rdchk(4'h0, {31'h0, m_ext});
            end
            working_i <= r[7:0];
            status_i <= r[15:8];
            bank_select_reg_i <= r[19:16];
            index_base_i <= r[31:20];
            k = i % 6;
            case (k)
                0: run(1'b1, {7'h76, i[1], r[7:0]},
                    {4'hf, r[31:20]});
                1: run(1'b1, {7'h35, 1'b0, r[7:0]}, r[15:0]);
                2: run(1'b1, {7'h35, 1'b1, r[7:0]}, r[15:0]);
                3: begin
                    timeout_evt_i <= r[0];
                    sleep_evt_i <= r[1];
                    clk(1);
                    timeout_evt_i <= 1'b0;
                    sleep_evt_i <= 1'b0;
                    m_tmo = m_tmo & !r[0];
                    m_pwr = m_pwr & !r[1];
                    clk(1);
                    run(1'b1, 16'h0004, r[15:0]);
                end
                4: run(1'b0, r[15:0], r[31:16]);
                default: run(1'b1, {7'h35, 1'b0, 8'h5f + 8'(i[1])},
                    16'h0);
            endcase
        end
        clk(1);
        rdchk(4'h8, {11'h0, m_pc});
        conclude();
    end
endmodule
